// ---- rtl/tsl_pkg.sv ----
// package: register map, field layout, reset values and states of the step timer limits block
package tsl_pkg;

  localparam int          TSL_AW           = 4;
  localparam int          TSL_DW           = 16;
  localparam int          TSL_NSTEP        = 16;
  localparam int          TSL_PW           = 4;
  localparam int          TSL_CW           = 4;

  // register offsets
  localparam logic [3:0]  TSL_OFS_CTRL     = 4'h0;
  localparam logic [3:0]  TSL_OFS_STATUS   = 4'h1;
  localparam logic [3:0]  TSL_OFS_T0LIM    = 4'h2;
  localparam logic [3:0]  TSL_OFS_T1LIM    = 4'h3;
  localparam logic [3:0]  TSL_OFS_STEPADR  = 4'h4;
  localparam logic [3:0]  TSL_OFS_STEPDAT  = 4'h5;

  // control field positions
  localparam int          TSL_CTRL_EN_BIT  = 0;
  localparam int          TSL_CTRL_STR_BIT = 1;

  // status field positions
  localparam int          TSL_ST_BUSY_BIT  = 0;
  localparam int          TSL_ST_PC_LSB    = 4;
  localparam int          TSL_ST_CMD_LSB   = 8;

  // reset values
  localparam logic [15:0] TSL_LIM_RST      = 16'h0000;
  localparam logic [15:0] TSL_CNT_RST      = 16'h0000;

  // step command codes
  localparam logic [3:0]  TSL_CMD_NOP      = 4'h0;
  localparam logic [3:0]  TSL_CMD_T0WAIT   = 4'h1;
  localparam logic [3:0]  TSL_CMD_T1WAIT   = 4'h2;
  localparam logic [3:0]  TSL_CMD_STOP     = 4'hf;

  typedef enum logic [1:0] {
    TSL_IDLE,
    TSL_FETCH,
    TSL_EXEC
  } tsl_state_t;

  typedef struct packed {
    logic [TSL_AW-1:0] addr;
    logic [TSL_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } tsl_bus_req_t;

endpackage : tsl_pkg

// ---- rtl/tsl_step_mem.sv ----
// step command memory: one write port, registered read data
`timescale 1ns/1ps
module tsl_step_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int W     = 4
) (
  // clock
  input  wire logic          clk,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // read side
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule : tsl_step_mem

// ---- rtl/tsl_step_timer.sv ----
// trigger sequencer core with the two step timer limit registers
//
// Contract
// - 16-bit timer0 limit used only by the timer0 wait step.
// - 16-bit timer1 limit used only by the timer1 wait step.
// - timer0 limit writes dropped while enable and start are both set.
// - timer1 limit writes dropped while enable and start are both set.
`timescale 1ns/1ps
module tsl_step_timer
  import tsl_pkg::*;
#(
  parameter int NSTEP = TSL_NSTEP
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // register port
  input  wire tsl_bus_req_t        bus_req,
  output logic      [TSL_DW-1:0]   rdata,
  // sequencer state
  output logic                     sequencer_enable_flag,
  output logic                     sequence_start_flag,
  output logic                     step_busy,
  output logic      [TSL_CW-1:0]   step_cmd
);

  logic [TSL_DW-1:0] step_timer0_limit_q;
  logic [TSL_DW-1:0] step_timer1_limit_q;
  logic [TSL_DW-1:0] wait_cnt_q;
  logic [TSL_PW-1:0] pc_q;
  logic [TSL_PW-1:0] step_adr_q;
  logic [TSL_CW-1:0] cmd_q;
  logic [TSL_CW-1:0] mem_rdata;
  logic              en_q;
  logic              start_q;
  tsl_state_t        state_q;
  logic              locked;
  logic              wr_ctrl;
  logic              wr_t0;
  logic              wr_t1;
  logic              wr_adr;
  logic              wr_dat;
  logic              wait_done;
  logic [TSL_DW-1:0] cur_limit;

  function automatic logic hit(input tsl_bus_req_t r, input logic [TSL_AW-1:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction : hit

  // register images built from the package field positions
  function automatic logic [TSL_DW-1:0] ctrl_word(input logic en, input logic start);
    ctrl_word                   = '0;
    ctrl_word[TSL_CTRL_EN_BIT]  = en;
    ctrl_word[TSL_CTRL_STR_BIT] = start;
  endfunction : ctrl_word

  function automatic logic [TSL_DW-1:0] status_word(input logic              busy,
                                                     input logic [TSL_PW-1:0] pc,
                                                     input logic [TSL_CW-1:0] cmd);
    status_word                           = '0;
    status_word[TSL_ST_BUSY_BIT]          = busy;
    status_word[TSL_ST_PC_LSB +: TSL_PW]  = pc;
    status_word[TSL_ST_CMD_LSB +: TSL_CW] = cmd;
  endfunction : status_word

  assign locked  = en_q && start_q;
  assign wr_ctrl = hit(bus_req, TSL_OFS_CTRL);
  assign wr_t0   = hit(bus_req, TSL_OFS_T0LIM) && !locked;
  assign wr_t1   = hit(bus_req, TSL_OFS_T1LIM) && !locked;
  assign wr_adr  = hit(bus_req, TSL_OFS_STEPADR);
  assign wr_dat  = hit(bus_req, TSL_OFS_STEPDAT) && !locked;

  // limit registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      step_timer0_limit_q <= TSL_LIM_RST;
    end else if (wr_t0) begin
      step_timer0_limit_q <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      step_timer1_limit_q <= TSL_LIM_RST;
    end else if (wr_t1) begin
      step_timer1_limit_q <= bus_req.wdata;
    end
  end

  // step program address pointer, auto-increments on data writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      step_adr_q <= '0;
    end else if (wr_adr) begin
      step_adr_q <= bus_req.wdata[TSL_PW-1:0];
    end else if (wr_dat) begin
      step_adr_q <= step_adr_q + 1'b1;
    end
  end

  tsl_step_mem #(
    .DEPTH (NSTEP),
    .AW    (TSL_PW),
    .W     (TSL_CW)
  ) u_mem (
    .clk   (clk),
    .we    (wr_dat),
    .waddr (step_adr_q),
    .wdata (bus_req.wdata[TSL_CW-1:0]),
    .raddr (pc_q),
    .rdata (mem_rdata)
  );

  // enable is software owned; start also drops when the program stops
  // a control write in the stop cycle wins over the hardware clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      en_q <= 1'b0;
    end else if (wr_ctrl) begin
      en_q <= bus_req.wdata[TSL_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_q <= 1'b0;
    end else if (wr_ctrl) begin
      start_q <= bus_req.wdata[TSL_CTRL_STR_BIT];
    end else if (state_q == TSL_EXEC && cmd_q == TSL_CMD_STOP) begin
      start_q <= 1'b0;
    end
  end

  // only the wait steps select a limit; others never see one
  always_comb begin
    unique case (cmd_q)
      TSL_CMD_T0WAIT: cur_limit = step_timer0_limit_q;
      TSL_CMD_T1WAIT: cur_limit = step_timer1_limit_q;
      default:        cur_limit = TSL_CNT_RST;
    endcase
  end

  assign wait_done = (wait_cnt_q >= cur_limit);

  // sequencer: fetch takes two cycles for the registered memory read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= TSL_IDLE;
      pc_q    <= '0;
      cmd_q   <= TSL_CMD_NOP;
    end else if (!locked) begin
      state_q <= TSL_IDLE;
      if (!en_q) begin
        pc_q <= '0;
      end
    end else begin
      unique case (state_q)
        TSL_IDLE: begin
          state_q <= TSL_FETCH;
        end
        TSL_FETCH: begin
          cmd_q   <= mem_rdata;
          state_q <= TSL_EXEC;
        end
        TSL_EXEC: begin
          unique case (cmd_q)
            TSL_CMD_T0WAIT, TSL_CMD_T1WAIT: begin
              if (wait_done) begin
                pc_q    <= pc_q + 1'b1;
                state_q <= TSL_IDLE;
              end
            end
            TSL_CMD_STOP: begin
              pc_q    <= '0;
              state_q <= TSL_IDLE;
            end
            default: begin
              pc_q    <= pc_q + 1'b1;
              state_q <= TSL_IDLE;
            end
          endcase
        end
        default: state_q <= TSL_IDLE;
      endcase
    end
  end

  // wait counter restarts from zero for every step
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_cnt_q <= TSL_CNT_RST;
    end else if (state_q == TSL_EXEC && locked && !wait_done) begin
      wait_cnt_q <= wait_cnt_q + 1'b1;
    end else begin
      wait_cnt_q <= TSL_CNT_RST;
    end
  end

  // read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        TSL_OFS_CTRL:    rdata <= ctrl_word(en_q, start_q);
        TSL_OFS_STATUS:  rdata <= status_word(state_q != TSL_IDLE, pc_q, cmd_q);
        TSL_OFS_T0LIM:   rdata <= step_timer0_limit_q;
        TSL_OFS_T1LIM:   rdata <= step_timer1_limit_q;
        TSL_OFS_STEPADR: rdata <= TSL_DW'(step_adr_q);
        default:         rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end

  assign sequencer_enable_flag = en_q;
  assign sequence_start_flag   = start_q;
  assign step_busy             = state_q != TSL_IDLE;
  assign step_cmd              = cmd_q;

endmodule : tsl_step_timer

// ---- test/tb_top.sv ----
// testbench for the step timer limit block
`timescale 1ns/1ps
module tb_top;
  import tsl_pkg::*;
  logic         clk;
  logic         nrst;
  tsl_bus_req_t bus_req;
  logic [15:0]  rdata;
  logic         en_f;
  logic         st_f;
  logic         step_busy;
  logic [3:0]   step_cmd;
  int           err_count;
  int           check_count;
  int           n;
  logic [15:0]  v;

  tsl_step_timer u_tsl_step_timer (.clk(clk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
    .sequencer_enable_flag(en_f), .sequence_start_flag(st_f), .step_busy(step_busy), .step_cmd(step_cmd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // gap cycle after each strobe so no signal is driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge clk);
    bus_req.wr    <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge clk);
    bus_req.rd   <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : rd

  // busy is looked at on falling edges, where it is settled; returns on a rising edge
  task automatic wait_busy(input logic b);
    n = 0;
    @(negedge clk);
    while (step_busy !== b && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (step_busy !== b) begin
      err_count++;
      $display("MISMATCH %0t busy wait timed out", $time);
      report_and_stop();
    end
    @(posedge clk);
  endtask : wait_busy

  // counts busy cycles from the next falling edge on; returns on a rising edge
  task automatic count_busy(output logic [15:0] c);
    c = 16'h0000;
    @(negedge clk);
    while (step_busy === 1'b1 && c < 16'h012c) begin
      c++;
      @(negedge clk);
    end
    if (c == 16'h012c) begin
      err_count++;
      $display("MISMATCH %0t busy count ran out", $time);
      report_and_stop();
    end
    @(posedge clk);
  endtask : count_busy

  task automatic run_lock();
    wr(TSL_OFS_T0LIM, 16'h0003);
    wr(TSL_OFS_T1LIM, 16'h0028);
    wr(TSL_OFS_STEPADR, 16'h0000);
    wr(TSL_OFS_STEPDAT, {12'h000, TSL_CMD_T0WAIT});
    wr(TSL_OFS_STEPDAT, {12'h000, TSL_CMD_T1WAIT});
    wr(TSL_OFS_STEPDAT, {12'h000, TSL_CMD_STOP});
    wr(TSL_OFS_CTRL, 16'h0003);
    wait_busy(1'b1);
    count_busy(v);
    chk(v, 16'h0004);
    wait_busy(1'b1);
    chk({14'h0, st_f, en_f}, 16'h0003);
    wr(TSL_OFS_T0LIM, 16'h1234);
    wr(TSL_OFS_T1LIM, 16'h5678);
    rd(TSL_OFS_T0LIM, v);
    chk(v, 16'h0003);
    rd(TSL_OFS_T1LIM, v);
    chk(v, 16'h0028);
    wait_busy(1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (4) @(posedge clk);
    wr(TSL_OFS_T1LIM, 16'hffff);
    rd(TSL_OFS_T1LIM, v);
    chk(v, 16'hffff);
  endtask : run_lock

  // small limits: each wait step runs limit plus one cycles of its own timer
  task automatic run_limits();
    wr(TSL_OFS_T0LIM, 16'h0001);
    wr(TSL_OFS_T1LIM, 16'h0005);
    wr(TSL_OFS_CTRL, 16'h0003);
    wait_busy(1'b1);
    count_busy(v);
    chk(v, 16'h0002);
    wait_busy(1'b1);
    count_busy(v);
    chk(v, 16'h0006);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk({12'h000, step_cmd}, {12'h000, TSL_CMD_STOP});
    rd(TSL_OFS_CTRL, v);
    chk(v, 16'h0001);
  endtask : run_limits

  initial begin
    nrst          = 1'b0;
    bus_req       = '0;
    err_count     = 0;
    check_count   = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(TSL_OFS_T0LIM, v);
    chk(v, 16'h0000);
    rd(TSL_OFS_T1LIM, v);
    chk(v, 16'h0000);
    rd(4'hf, v);
    chk(v, 16'h0000);
    wr(TSL_OFS_T0LIM, 16'hffff);
    rd(TSL_OFS_T0LIM, v);
    chk(v, 16'hffff);
    run_lock();
    run_limits();
    report_and_stop();
  end
endmodule : tb_top

// ---- test/tsl_step_timer_monitor.sv ----
// checker for the step timer limit block ports
`timescale 1ns/1ps
module tsl_step_timer_monitor
  import tsl_pkg::*;
#(
  parameter int NSTEP = TSL_NSTEP
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // register port
  input wire tsl_bus_req_t      bus_req,
  input wire logic [TSL_DW-1:0] rdata,
  // sequencer state
  input wire logic              sequencer_enable_flag,
  input wire logic              sequence_start_flag,
  input wire logic              step_busy,
  input wire logic [TSL_CW-1:0] step_cmd
);
  logic        run;
  logic [15:0] l0_q;
  logic [15:0] l1_q;

  assign run = sequencer_enable_flag && sequence_start_flag;

  // shadow copies; writes while running must not land
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      l0_q <= TSL_LIM_RST;
      l1_q <= TSL_LIM_RST;
    end else if (bus_req.wr && !run) begin
      if (bus_req.addr == TSL_OFS_T0LIM) l0_q <= bus_req.wdata;
      if (bus_req.addr == TSL_OFS_T1LIM) l1_q <= bus_req.wdata;
    end
  end

  a_t0_lim_read: assert property (@(posedge clk) disable iff (!nrst)
    bus_req.rd && bus_req.addr == TSL_OFS_T0LIM |=> rdata == $past(l0_q)) else $error("timer0 limit read wrong");
  a_t1_lim_read: assert property (@(posedge clk) disable iff (!nrst)
    bus_req.rd && bus_req.addr == TSL_OFS_T1LIM |=> rdata == $past(l1_q)) else $error("timer1 limit read wrong");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
    !$past(bus_req.rd) |-> rdata == 16'h0000) else $error("read data outside read slot");
  a_busy_needs_run: assert property (@(posedge clk) disable iff (!nrst)
    $rose(step_busy) |-> $past(run)) else $error("step started while not running");
  a_ctrl_read: assert property (@(posedge clk) disable iff (!nrst)
    bus_req.rd && bus_req.addr == TSL_OFS_CTRL |=>
      rdata == {14'h0, $past(sequence_start_flag), $past(sequencer_enable_flag)}) else $error("control read wrong");
  a_stop_idles: assert property (@(posedge clk) disable iff (!nrst)
    $fell(sequence_start_flag) && !($past(bus_req.wr) && $past(bus_req.addr) == TSL_OFS_CTRL) |-> !step_busy)
    else $error("start dropped while still busy");
endmodule : tsl_step_timer_monitor

bind tsl_step_timer tsl_step_timer_monitor #(.NSTEP(NSTEP)) u_tsl_step_timer_monitor (.clk(clk), .nrst(nrst),
  .bus_req(bus_req), .rdata(rdata), .sequencer_enable_flag(sequencer_enable_flag),
  .sequence_start_flag(sequence_start_flag), .step_busy(step_busy), .step_cmd(step_cmd));
